// *** common/rdc_pkg.sv ***
// shared constants and types of the receiver duty-cycle sequencer
package rdc_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS         = 1000;
  localparam int US_CYC        = US_NS / CLK_PERIOD_NS;
  localparam int US_PER_MS     = 1000;
  localparam int POR_US        = 500;
  localparam int TUNE_US       = 300;
  localparam int SLEEP_MS_MIN  = 3;
  localparam int SLEEP_MS_RST  = 3;
  localparam int XTAL_US_RST   = 310;
  localparam int RX_MS_RST     = 1000;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_SLEEP  = 8'h04;
  localparam logic [7:0] ADDR_XTAL   = 8'h08;
  localparam logic [7:0] ADDR_RX     = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  localparam int CTRL_DUTY_BIT = 0;
  localparam int CTRL_CLKEN_BIT = 1;
  localparam int CTRL_DIV_LSB  = 2;
  localparam int DIV_W         = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  localparam int ST_DOUT_BIT  = 5;
  localparam int ST_CLKON_BIT = 6;
  localparam int ST_RSTO_BIT  = 7;

  // ==========================================================
  // sequencer states
  typedef enum logic [4:0] {
    ST_PUP   = 5'b00001,
    ST_SLEEP = 5'b00010,
    ST_XTAL  = 5'b00100,
    ST_TUNE  = 5'b01000,
    ST_RX    = 5'b10000
  } rdc_state_e;

endpackage

// *** verilog/rdc_tick_gen.sv ***
// one-cycle microsecond tick, restartable at each phase entry
`timescale 1ns/100ps
module rdc_tick_gen #(
  parameter int DIV = 100
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic clr,
  // tick
  output logic      tick
);

  typedef struct packed {
    logic [15:0] cnt;
  } rdc_tick_s;

  rdc_tick_s r;
  rdc_tick_s next_r;

  // ==========================================================
  // divider
  always_comb begin
    next_r = r;
    tick   = (r.cnt == 16'(DIV - 1));
    if (clr || tick) begin
      next_r.cnt = '0;
    end else begin
      next_r.cnt = r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

// *** verilog/rdc_rx_ctrl.sv ***
// duty-cycle sequencer, reset output and clock output of a stand-alone receiver
//
// Operation
// - duty mode loops sleep, crystal settle, tune, receive until power goes away
// - tuning phase lasts 300 us, then receive starts
// - digital logic runs from the system clock standing for the crystal
// - sleep time can be set down to 3 ms, never below
// - receive gap equals sleep plus crystal settle plus tuning time in duty mode; always-receive mode skips the settle
// - demodulated data output is low whenever not receiving
// - receive window defaults to 1 second
// - active-low reset output follows internal power-on reset
// - power-on reset releases a fixed delay after supply is detected
// - reset output drops at once when supply falls
// - clock output is the system clock divided down when enabled
// - divided clock runs only in crystal settle, tune or receive
// - a configuration field selects the clock division
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/100ps
module rdc_rx_ctrl #(
  parameter int POR_US  = rdc_pkg::POR_US,
  parameter int TUNE_US = rdc_pkg::TUNE_US,
  parameter int US_CYC  = rdc_pkg::US_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // receive data
  input  wire logic        demod_data_in,
  output logic             demod_data_out,
  // system outputs
  output logic             reset_out_n,
  output logic             divided_clock_out
);

  // ==========================================================
  // state
  typedef struct packed {
    rdc_pkg::rdc_state_e         state;
    logic [37:0]                 cnt;
    logic [15:0]                 por_cnt;
    logic                        por_done;
    logic                        duty;
    logic                        clken;
    logic [rdc_pkg::DIV_W-1:0]   div;
    logic [27:0]                 sleep_ms;
    logic [15:0]                 xtal_us;
    logic [27:0]                 rx_ms;
    logic                        dsync1;
    logic                        dsync2;
    logic                        dout;
    logic [7:0]                  clk_cnt;
    logic                        clk_out;
    logic [31:0]                 rdata;
    logic                        err;
  } rdc_ctrl_s;

  localparam rdc_ctrl_s RST = '{
    state:    rdc_pkg::ST_PUP,
    cnt:      '0,
    por_cnt:  '0,
    por_done: 1'b0,
    duty:     rdc_pkg::CTRL_RST[rdc_pkg::CTRL_DUTY_BIT],
    clken:    rdc_pkg::CTRL_RST[rdc_pkg::CTRL_CLKEN_BIT],
    div:      rdc_pkg::CTRL_RST[rdc_pkg::CTRL_DIV_LSB +: rdc_pkg::DIV_W],
    sleep_ms: 28'(rdc_pkg::SLEEP_MS_RST),
    xtal_us:  16'(rdc_pkg::XTAL_US_RST),
    rx_ms:    28'(rdc_pkg::RX_MS_RST),
    dsync1:   1'b0,
    dsync2:   1'b0,
    dout:     1'b0,
    clk_cnt:  '0,
    clk_out:  1'b0,
    rdata:    '0,
    err:      1'b0
  };

  rdc_ctrl_s r;
  rdc_ctrl_s next_r;

  logic us_tick;
  logic tick_clr;
  logic clk_allow;
  logic phase_done;
  logic go;
  rdc_pkg::rdc_state_e nxt;

  // ==========================================================
  // helpers
  function automatic logic [37:0] ms_to_us(input logic [27:0] ms);
    return 38'(ms) * 38'(rdc_pkg::US_PER_MS);
  endfunction

  // phase length in microseconds, less one
  function automatic logic [37:0] phase_last(input rdc_pkg::rdc_state_e st, input rdc_ctrl_s c);
    logic [37:0] v;
    v = 38'h1;
    case (st)
      rdc_pkg::ST_SLEEP: v = c.duty ? ms_to_us(c.sleep_ms) : ms_to_us(28'(rdc_pkg::SLEEP_MS_MIN));
      rdc_pkg::ST_XTAL:  v = 38'(c.xtal_us);
      rdc_pkg::ST_TUNE:  v = 38'(TUNE_US);
      rdc_pkg::ST_RX:    v = ms_to_us(c.rx_ms);
      default:           v = 38'h1;
    endcase
    return v - 38'h1;
  endfunction

  // system clock stands for the crystal; all timing is whole microseconds of it
  rdc_tick_gen #(
    .DIV (US_CYC)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (tick_clr),
    .tick    (us_tick)
  );

  // ==========================================================
  // next state
  always_comb begin
    next_r = r;
    nxt    = r.state;
    go     = 1'b0;

    // data pin comes from the analog demodulator, not our clock
    next_r.dsync1 = demod_data_in;
    next_r.dsync2 = r.dsync1;

    // power-on reset delay counted from release of presetn
    if (!r.por_done && us_tick) begin
      if (r.por_cnt == 16'(POR_US - 1)) begin
        next_r.por_done = 1'b1;
      end else begin
        next_r.por_cnt = r.por_cnt + 16'h0001;
      end
    end

    phase_done = us_tick && (r.cnt == phase_last(r.state, r));

    // sequencer; gap before receive is sleep, then settle in duty mode only, then tune
    case (r.state)
      rdc_pkg::ST_PUP: begin
        if (r.por_done) begin
          go  = 1'b1;
          nxt = rdc_pkg::ST_SLEEP;
        end
      end
      rdc_pkg::ST_SLEEP: begin
        if (phase_done) begin
          go  = 1'b1;
          nxt = r.duty ? rdc_pkg::ST_XTAL : rdc_pkg::ST_TUNE;
        end
      end
      rdc_pkg::ST_XTAL: begin
        if (phase_done) begin
          go  = 1'b1;
          nxt = rdc_pkg::ST_TUNE;
        end
      end
      rdc_pkg::ST_TUNE: begin
        if (phase_done) begin
          go  = 1'b1;
          nxt = rdc_pkg::ST_RX;
        end
      end
      rdc_pkg::ST_RX: begin
        // always-receive mode stays here until power goes away
        if (phase_done && r.duty) begin
          go  = 1'b1;
          nxt = rdc_pkg::ST_SLEEP;
        end
      end
      default: begin
        go  = 1'b1;
        nxt = rdc_pkg::ST_PUP;
      end
    endcase

    tick_clr = go;
    if (go) begin
      next_r.state = nxt;
      next_r.cnt   = '0;
    end else if (us_tick && r.state != rdc_pkg::ST_PUP) begin
      next_r.cnt = r.cnt + 38'h1;
    end

    // data is only passed while receiving; keyed to the state being entered so the
    // pin is already low in the first cycle of the gap
    next_r.dout = (next_r.state == rdc_pkg::ST_RX) && r.dsync2;

    // divided clock; half period is 1, 2, 4 or 8 system cycles
    // gated on the state being entered, so sleep never sees a leftover high cycle
    clk_allow = r.clken && (next_r.state == rdc_pkg::ST_XTAL || next_r.state == rdc_pkg::ST_TUNE
                            || next_r.state == rdc_pkg::ST_RX);
    if (!clk_allow) begin
      next_r.clk_cnt = '0;
      next_r.clk_out = 1'b0;
    end else if (r.clk_cnt >= (8'h01 << r.div) - 8'h01) begin
      next_r.clk_cnt = '0;
      next_r.clk_out = !r.clk_out;
    end else begin
      next_r.clk_cnt = r.clk_cnt + 8'h01;
    end

    // apb: read data and error caught in setup, writes land in access
    if (psel && !penable) begin
      next_r.err   = 1'b0;
      next_r.rdata = '0;
      if (paddr == rdc_pkg::ADDR_CTRL) begin
        next_r.rdata[rdc_pkg::CTRL_DUTY_BIT]  = r.duty;
        next_r.rdata[rdc_pkg::CTRL_CLKEN_BIT] = r.clken;
        next_r.rdata[rdc_pkg::CTRL_DIV_LSB +: rdc_pkg::DIV_W] = r.div;
      end else if (paddr == rdc_pkg::ADDR_SLEEP) begin
        next_r.rdata = 32'(r.sleep_ms);
      end else if (paddr == rdc_pkg::ADDR_XTAL) begin
        next_r.rdata = 32'(r.xtal_us);
      end else if (paddr == rdc_pkg::ADDR_RX) begin
        next_r.rdata = 32'(r.rx_ms);
      end else if (paddr == rdc_pkg::ADDR_STATUS) begin
        next_r.rdata[4:0] = r.state;
        next_r.rdata[rdc_pkg::ST_DOUT_BIT]  = r.dout;
        next_r.rdata[rdc_pkg::ST_CLKON_BIT] = clk_allow;
        next_r.rdata[rdc_pkg::ST_RSTO_BIT]  = r.por_done;
      end else begin
        next_r.err = 1'b1;
      end
    end
    if (psel && penable && pwrite) begin
      if (paddr == rdc_pkg::ADDR_CTRL) begin
        next_r.duty  = pwdata[rdc_pkg::CTRL_DUTY_BIT];
        next_r.clken = pwdata[rdc_pkg::CTRL_CLKEN_BIT];
        next_r.div   = pwdata[rdc_pkg::CTRL_DIV_LSB +: rdc_pkg::DIV_W];
      end else if (paddr == rdc_pkg::ADDR_SLEEP) begin
        // shorter sleep than the timer floor is raised to the floor
        if (pwdata[27:0] < 28'(rdc_pkg::SLEEP_MS_MIN)) begin
          next_r.sleep_ms = 28'(rdc_pkg::SLEEP_MS_MIN);
        end else begin
          next_r.sleep_ms = pwdata[27:0];
        end
      end else if (paddr == rdc_pkg::ADDR_XTAL) begin
        next_r.xtal_us = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end else if (paddr == rdc_pkg::ADDR_RX) begin
        next_r.rx_ms = (pwdata[27:0] == 28'h000_0000) ? 28'h000_0001 : pwdata[27:0];
      end
    end
  end

  // ==========================================================
  // registers; presetn stands for the supply, so its fall clears at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= RST;
    end else begin
      r <= next_r;
    end
  end

  assign pready            = psel && penable;
  assign prdata            = r.rdata;
  assign pslverr           = r.err && psel && penable;
  assign demod_data_out    = r.dout;
  assign reset_out_n       = r.por_done;
  assign divided_clock_out = r.clk_out;

  // ==========================================================
  // checks
  localparam int TUNE_CYC = TUNE_US * US_CYC;
  localparam int POR_CYC  = POR_US * US_CYC;

  logic [31:0] stay;
  logic [31:0] up_cyc;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stay   <= '0;
      up_cyc <= '0;
    end else begin
      stay   <= (next_r.state != r.state) ? 32'h0000_0000 : stay + 32'h0000_0001;
      up_cyc <= (up_cyc == 32'hFFFF_FFFF) ? up_cyc : up_cyc + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_rx_left;
    (r.state == rdc_pkg::ST_RX) ##1 (r.state != rdc_pkg::ST_RX);
  endsequence

  sequence seq_tune_to_rx;
    (r.state == rdc_pkg::ST_TUNE) ##1 (r.state == rdc_pkg::ST_RX);
  endsequence

  chk_rx_to_sleep: assert property (seq_rx_left |-> r.state == rdc_pkg::ST_SLEEP)
    else $error("receive left to a state other than sleep");

  chk_sleep_to_xtal: assert property ((r.state == rdc_pkg::ST_SLEEP && r.duty)
    ##1 (r.state != rdc_pkg::ST_SLEEP) |-> r.state == rdc_pkg::ST_XTAL)
    else $error("duty mode sleep not followed by crystal settle");

  chk_tune_len: assert property (seq_tune_to_rx |-> $past(stay) == 32'(TUNE_CYC - 1))
    else $error("tuning phase length wrong");

  chk_sleep_floor: assert property (r.sleep_ms >= 28'(rdc_pkg::SLEEP_MS_MIN))
    else $error("sleep time below floor");

  chk_dout_gap: assert property (r.state != rdc_pkg::ST_RX |-> !demod_data_out)
    else $error("data output not low outside receive");

  chk_rsto_hold: assert property ((up_cyc < 32'(POR_CYC)) |-> !reset_out_n)
    else $error("reset output released before power-on reset");

  chk_por_delay: assert property ($rose(reset_out_n) |-> up_cyc == 32'(POR_CYC))
    else $error("reset output released at wrong time");

  chk_clk_quiet: assert property (!clk_allow |=> !divided_clock_out)
    else $error("divided clock active while not allowed");

  chk_clk_div2: assert property ((clk_allow && r.div == '0) |=>
    divided_clock_out != $past(divided_clock_out))
    else $error("divide-by-two clock failed to toggle");

  chk_clk_state: assert property ($rose(divided_clock_out) |-> $past(clk_allow))
    else $error("divided clock rose outside its states");

  sequence seq_xtal_left;
    (r.state == rdc_pkg::ST_XTAL) ##1 (r.state != rdc_pkg::ST_XTAL);
  endsequence

  chk_xtal_to_tune: assert property (seq_xtal_left |-> r.state == rdc_pkg::ST_TUNE)
    else $error("crystal settle not followed by tuning");

  chk_dout_pass: assert property ((next_r.state == rdc_pkg::ST_RX) |=>
    demod_data_out == $past(r.dsync2))
    else $error("data output not following input while receiving");

  chk_always_rx: assert property ((r.state == rdc_pkg::ST_RX && !r.duty) |=> r.state == rdc_pkg::ST_RX)
    else $error("always-receive mode left receive");

endmodule

// *** verif/rdc_mcu_model.sv ***
// partner model: external controller that samples the data output level
`timescale 1ns/100ps
module rdc_mcu_model (
  // system clock, and reset from the device
  input  wire logic pclk,
  input  wire logic reset_out_n,
  // demodulated data level
  input  wire logic demod_data_out,
  // count of high samples taken
  output int        ones
);
  // ==========================================================
  // capture
  // held in reset by the device; no handshake, the level alone is taken
  always @(posedge pclk or negedge reset_out_n) begin
    if (!reset_out_n) begin
      ones <= 0;
    end else if (demod_data_out === 1'b1) begin
      ones <= ones + 1;
    end
  end
endmodule

// *** verif/tb_rx_duty_cycle_reset_clkout.sv ***
// self-checking bench of the receiver duty-cycle sequencer
`timescale 1ns/100ps
module tb_rx_duty_cycle_reset_clkout;
  // short counts keep the run small; every expectation derives from them
  localparam int POR = 2;
  localparam int TUN = 3;
  localparam int UC  = 2;
  localparam int SLP = 3 * 1000 * UC;
  localparam int RXC = 1000 * UC;

  // ==========================================================
  // signals
  logic        pclk, presetn, psel, penable, pwrite, demod_data_in, b, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, demod_data_out, reset_out_n, divided_clock_out;
  int          err_count, comparisons, ones, t0, t1, t2, t3, t4, t5, n, xt, o0;
  int          cyc  = 0;
  int          seed = 32'h0000_7182;
  logic        hist [$];
  logic [31:0] dflt [4] = '{rdc_pkg::CTRL_RST, 32'(rdc_pkg::SLEEP_MS_RST),
                            32'(rdc_pkg::XTAL_US_RST), 32'(rdc_pkg::RX_MS_RST)};

  rdc_rx_ctrl #(.POR_US(POR), .TUNE_US(TUN), .US_CYC(UC)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .demod_data_in(demod_data_in), .demod_data_out(demod_data_out),
    .reset_out_n(reset_out_n), .divided_clock_out(divided_clock_out));

  rdc_mcu_model mcu (.pclk(pclk), .reset_out_n(reset_out_n), .demod_data_out(demod_data_out), .ones(ones));

  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp, input int tol);
    comparisons++;
    if (!(seen === exp || (tol > 0 && !$isunknown(seen) && seen + tol >= exp && seen <= exp + tol))) begin
      err_count++;
      $display("unexpected %s: expected %0d seen %0d", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 0;
    penable <= 0;
  endtask

  // clk_sel picks the clock output, else the data output
  task automatic wait_for(input bit clk_sel, input logic v, output int t);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((clk_sel ? divided_clock_out : demod_data_out) !== v && n < 20000);
    t = cyc;
  endtask

  task automatic rst_seq();
    @(posedge pclk);
    presetn <= 0;
    #1 chk("reset out drop", reset_out_n, 0, 0);
    chk("clock out in reset", divided_clock_out, 0, 0);
    repeat (3) @(posedge pclk);
    presetn <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      #1 chk("data out in power-up", demod_data_out, 0, 0);
    end while (reset_out_n !== 1'b1 && n < 100);
    chk("por edges", n, POR * UC, 0);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge pclk);
    err_count++;
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    demod_data_in = 1;
    err_count = 0;
    comparisons = 0;
    rst_seq();
    apb(0, rdc_pkg::ADDR_STATUS, 0);
    chk("status", rd, 32'h0000_0082, 0);
    foreach (dflt[i]) begin
      apb(0, 8'(4 * i), 0);
      chk("reg default", rd, dflt[i], 0);
    end
    apb(1, 8'h14, 32'hFFFF_FFFF);
    chk("unmapped error", er, 1, 0);
    apb(1, rdc_pkg::ADDR_SLEEP, 1);
    apb(0, rdc_pkg::ADDR_SLEEP, 0);
    chk("sleep floor", rd, 3, 0);
    xt = 2 + ($random(seed) & 7);
    apb(1, rdc_pkg::ADDR_XTAL, xt);
    apb(1, rdc_pkg::ADDR_RX, 1);
    $display("test registers done");
    wait_for(0, 1, t1);
    wait_for(0, 0, t0);
    for (int d = 0; d < 4; d++) begin
      o0 = ones;
      apb(1, rdc_pkg::ADDR_CTRL, 32'(3 + 4 * d));
      wait_for(1, 1, t1);
      wait_for(0, 1, t2);
      wait_for(1, 0, t3);
      wait_for(1, 1, t3);
      wait_for(1, 0, t4);
      wait_for(1, 1, t4);
      if (d == 0) begin
        hist = {};
        // three back-to-back packets of random symbols
        repeat (48) begin
          @(posedge pclk);
          b = 1'($random(seed));
          demod_data_in <= b;
          hist.push_back(b);
          @(negedge pclk);
          if (hist.size() > 3) chk("data path", demod_data_out, hist[hist.size() - 4], 0);
        end
        @(posedge pclk);
        demod_data_in <= 1;
        repeat (4) @(negedge pclk);
      end
      wait_for(0, 0, t5);
      chk("clock start", t1 - t0, SLP + (1 << d) - 1, 1);
      chk("gap", t2 - t0, SLP + (xt + TUN) * UC, 3);
      chk("clock period", t4 - t3, 2 << d, 0);
      chk("rx window", t5 - t2, RXC, 3);
      if (d > 0) chk("captured highs", ones - o0, RXC, 4);
      t0 = t5;
    end
    $display("test duty loop done");
    apb(1, rdc_pkg::ADDR_CTRL, 1);
    wait_for(1, 1, t1);
    chk("clock idle when off", 32'(t1 - t0 > 16000), 1, 0);
    $display("test clock off done");
    rst_seq();
    t0 = cyc;
    apb(0, rdc_pkg::ADDR_STATUS, 0);
    chk("status after reset", rd, 32'h0000_0082, 0);
    $display("test second reset done");
    // always-receive mode: fixed short sleep, no crystal settle, then receive for good
    apb(1, rdc_pkg::ADDR_CTRL, 0);
    apb(1, rdc_pkg::ADDR_SLEEP, 5);
    wait_for(0, 1, t2);
    chk("always gap", t2 - t0, 1 + SLP + TUN * UC, 1);
    repeat (RXC + 100) @(negedge pclk);
    apb(0, rdc_pkg::ADDR_STATUS, 0);
    chk("always stays receiving", rd, 32'h0000_00B0, 0);
    $display("test always receive done");
    give_verdict();
  end
endmodule
